// ===== include/ssi_pkg.sv
`default_nettype none
package ssi_pkg;
    // Time base
    localparam int CLK_NS = 5;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_NS = 10_000_000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
    localparam int TICK_MS = TICK_NS / 1_000_000;
    localparam int BAUD_BPS = 115_200;
    localparam int BAUD_CYC = CLK_HZ / BAUD_BPS;

    // Pattern times in ms, converted to ticks
    localparam int BLIP_MS = 100;
    localparam int SLOW_PER_MS = 2000;
    localparam int HALF_MS = 500;
    localparam int SEC_MS = 1000;
    localparam int QUART_MS = 250;
    localparam int FAST_PER_MS = 200;
    localparam int CAP_MS = 10_000;
    localparam int WAIT_MS = 60_000;
    localparam int DONE_MS = 3000;
    localparam int NV_PER_MS = 60_000;
    localparam int NV_BURST_MS = 4000;
    localparam int ME_PER_MS = 300_000;
    localparam int ME_BURST_MS = 10_000;
    localparam int SVC_MS = 20_000;

    localparam logic [14:0] K_BLIP = 15'(BLIP_MS / TICK_MS);
    localparam logic [14:0] K_SLOW = 15'(SLOW_PER_MS / TICK_MS);
    localparam logic [14:0] K_HALF = 15'(HALF_MS / TICK_MS);
    localparam logic [14:0] K_SEC = 15'(SEC_MS / TICK_MS);
    localparam logic [14:0] K_QUART = 15'(QUART_MS / TICK_MS);
    localparam logic [14:0] K_FAST = 15'(FAST_PER_MS / TICK_MS);
    localparam logic [14:0] K_CAP = 15'(CAP_MS / TICK_MS);
    localparam logic [14:0] K_WAIT = 15'(WAIT_MS / TICK_MS);
    localparam logic [14:0] K_DONE = 15'(DONE_MS / TICK_MS);
    localparam logic [14:0] K_NV_PER = 15'(NV_PER_MS / TICK_MS);
    localparam logic [14:0] K_NV_BURST = 15'(NV_BURST_MS / TICK_MS);
    localparam logic [14:0] K_ME_PER = 15'(ME_PER_MS / TICK_MS);
    localparam logic [14:0] K_ME_BURST = 15'(ME_BURST_MS / TICK_MS);
    localparam logic [14:0] K_SVC = 15'(SVC_MS / TICK_MS);

    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_START = 8'h08;
    localparam logic [7:0] REG_NOM = 8'h0C;
    localparam logic [7:0] REG_CMD = 8'h10;
    localparam int CTRL_BUZZ_OFF = 0;
    localparam int CTRL_RANGE0 = 1;
    localparam int CTRL_TEACH = 2;
    localparam int CTRL_SVC = 3;

    // Output scale in millivolts, then position limits and minimum teach span on position_i
    localparam logic [13:0] MV_LOW = 14'h07D0;
    localparam logic [13:0] MV_SPAN_2 = 14'h1F40;
    localparam logic [13:0] MV_SPAN_0 = 14'h2710;
    localparam logic [13:0] MV_MAX_AIR = 14'h2710;
    localparam logic [13:0] MV_OPEN = 14'h2710;
    localparam logic [11:0] POS_MIN = 12'h010;
    localparam logic [11:0] POS_MAX = 12'hFEF;
    localparam logic [11:0] MIN_SPAN = 12'h040;

    typedef enum logic [3:0] {
        IND_OFF, IND_READY, IND_LOWSUP, IND_CAPS, IND_WAIT, IND_CAPN,
        IND_OK, IND_FAIL, IND_NOVAL, IND_MEAS, IND_SVC, IND_FAULT
    } ssi_ind_type;

    typedef enum logic [2:0] {
        TS_NOVAL, TS_CAPS, TS_WAIT, TS_CAPN, TS_OK, TS_FAIL, TS_READY
    } ssi_teach_type;

    typedef struct packed {
        logic supply_ok;
        logic supply_low;
        logic spring_low;
        logic short_travel;
        logic excess_travel;
        logic teach_btn;
        logic alarm_pin;
    } ssi_pins_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ssi_bus_type;

    typedef struct packed {
        ssi_pins_type sync1;
        ssi_pins_type sync2;
        ssi_pins_type sync3;
        ssi_pins_type filt;
        logic btn_prev;
        logic [20:0] tick_cnt;
        logic tick;
        logic [10:0] baud_cnt;
        logic baud_en;
        ssi_teach_type teach;
        logic [14:0] tcnt;
        logic valid;
        logic dir_open;
        logic [11:0] start_pos;
        logic [11:0] nom_pos;
        logic buzz_off;
        logic range0;
        logic svc;
        logic [14:0] svc_cnt;
        ssi_ind_type ind;
        logic [14:0] phase;
        logic led_r;
        logic led_g;
        logic buzz;
        logic alarm_oe;
        logic meas_err;
        logic [13:0] cmd_mv;
        logic [31:0] rdata;
    } ssi_state_type;

    localparam ssi_state_type ST_RST = '0;
endpackage
`default_nettype wire

// ===== hw/ssi_top.sv
`default_nettype none
// Overview of operation
// - Ready with good supply: green blink 0.1 s on, 1.9 s off, buzzer quiet.
// - Supply present but low: orange blink 0.1 s on, 1.9 s off, buzzer quiet.
// - Start capture: orange blink and buzzer 0.5/0.5 s for 10 s.
// - Awaiting position change: orange and buzzer steady, under 60 s.
// - Nominal capture: orange blink and buzzer 0.25/0.25 s for 10 s.
// - Teach success: green and buzzer steady for 3 s.
// - Teach failure: red blink 0.1/0.1 s with buzzer on for 3 s.
// - No learned values: orange steady, buzzer 0.5/0.5 s for 4 s every 60 s.
// - Flag measurement error when the measured value leaves its expected range.
// - Measurement error: red steady, buzzer 0.5/0.5 s for 10 s every 300 s.
// - Service mode: red/green alternate 0.5 s, buzzer 0.1/1.9 s, 20 s.
// - Service mode ends 20 s after link traffic stops.
// - Spring or travel fault: orange and red alternate 0.5 s.
// - Alarm output active while a spring or travel fault exists.
// - Spring force too low forces command output to maximum air volume.
// - Service mode with measurement error sets command to open-sash value.
// - Teach stores which spring direction means opening and applies it.
// - Map 0..100 % of learned travel linearly onto 2..10 V, or onto 0..10 V when range0 is set.
// - Output range defaults to 2..10 V after reset.
// - Serial link runs at fixed 115.2 kbit/s.
// - A setting mutes the buzzer, LED patterns unchanged.
module ssi_top
    import ssi_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire ssi_pins_type pins_i,
    input wire logic [11:0] position_i,
    input wire ssi_bus_type bus_i,
    output logic [31:0] rdata_o,
    output logic led_red_o,
    output logic led_green_o,
    output logic buzzer_o,
    output logic alarm_o,
    output logic alarm_oe_o,
    output logic [13:0] cmd_mv_o,
    output logic baud_en_o
);

    ssi_state_type r;
    ssi_state_type n;

    function automatic logic blink(input logic [14:0] p, input logic [14:0] on,
                                   input logic [14:0] per);
        blink = (p % per) < on;
    endfunction

    function automatic logic [14:0] ind_period(input ssi_ind_type s);
        unique case (s)
            IND_READY, IND_LOWSUP, IND_SVC: ind_period = K_SLOW;
            IND_NOVAL: ind_period = K_NV_PER;
            IND_MEAS: ind_period = K_ME_PER;
            default: ind_period = K_SEC;
        endcase
    endfunction

    logic fault;
    logic trig;
    logic t_done;
    logic [11:0] travel;
    logic [11:0] span;
    logic [25:0] prod;
    logic [25:0] quot;
    logic [13:0] scaled;
    ssi_ind_type ind_sel;

    always_comb begin
        n = r;
        // Synchroniser chain; a change counts once stages two and three agree
        n.sync1 = pins_i;
        n.sync2 = r.sync1;
        n.sync3 = r.sync2;
        n.filt = ssi_pins_type'((r.sync2 & r.sync3) | (r.filt & (r.sync2 ^ r.sync3)));
        n.btn_prev = r.filt.teach_btn;

        // Common timebase tick
        n.tick = 1'b0;
        if (r.tick_cnt == 21'(TICK_CYC - 1)) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = r.tick_cnt + 21'h000001;
        end

        // Fixed bit-rate enable for the serial link
        n.baud_en = 1'b0;
        if (r.baud_cnt == 11'(BAUD_CYC - 1)) begin
            n.baud_cnt = '0;
            n.baud_en = 1'b1;
        end else begin
            n.baud_cnt = r.baud_cnt + 11'h001;
        end

        fault = r.filt.spring_low | r.filt.short_travel | r.filt.excess_travel;
        n.alarm_oe = fault;
        n.meas_err = (position_i < POS_MIN) || (position_i > POS_MAX);

        // Register port; any access counts as link traffic
        n.rdata = '0;
        // Detector starts low like the idle button, so leaving reset gives no false edge
        trig = r.filt.teach_btn & ~r.btn_prev;
        if (bus_i.wr && bus_i.addr == REG_CTRL) begin
            n.buzz_off = bus_i.wdata[CTRL_BUZZ_OFF];
            n.range0 = bus_i.wdata[CTRL_RANGE0];
            if (bus_i.wdata[CTRL_TEACH]) begin
                trig = 1'b1;
            end
            if (bus_i.wdata[CTRL_SVC]) begin
                n.svc = 1'b1;
            end
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                REG_CTRL: n.rdata = {28'h0000000, r.svc, 1'b0, r.range0, r.buzz_off};
                REG_STAT: n.rdata = {13'h0000, r.filt, r.ind, r.teach, r.svc,
                                     r.meas_err, r.alarm_oe, r.valid, r.dir_open};
                REG_START: n.rdata = {20'h00000, r.start_pos};
                REG_NOM: n.rdata = {20'h00000, r.nom_pos};
                REG_CMD: n.rdata = {18'h00000, r.cmd_mv};
                default: n.rdata = '0;
            endcase
        end

        // Service mode retriggered by traffic, dropped after a silent 20 s
        if (bus_i.wr || bus_i.rd) begin
            n.svc_cnt = '0;
        end else if (r.svc && r.tick) begin
            if (r.svc_cnt == K_SVC - 15'h0001) begin
                n.svc = 1'b0;
                n.svc_cnt = '0;
            end else begin
                n.svc_cnt = r.svc_cnt + 15'h0001;
            end
        end

        // Teach-in sequence
        t_done = 1'b0;
        if (r.tick) begin
            n.tcnt = r.tcnt + 15'h0001;
        end
        unique case (r.teach)
            TS_NOVAL, TS_READY: begin
                if (trig) begin
                    n.teach = TS_CAPS;
                    n.valid = 1'b0;
                end
            end
            TS_CAPS: begin
                t_done = r.tick && r.tcnt == K_CAP - 15'h0001;
                if (t_done) begin
                    n.start_pos = position_i;
                    n.teach = TS_WAIT;
                end
            end
            TS_WAIT: begin
                // Operator gets under 60 s to confirm the nominal position
                if (trig) begin
                    n.teach = TS_CAPN;
                end else if (r.tick && r.tcnt == K_WAIT - 15'h0002) begin
                    n.teach = TS_FAIL;
                end
            end
            TS_CAPN: begin
                t_done = r.tick && r.tcnt == K_CAP - 15'h0001;
                if (t_done) begin
                    n.nom_pos = position_i;
                    n.dir_open = position_i > r.start_pos;
                    if ((position_i > r.start_pos &&
                         position_i - r.start_pos >= MIN_SPAN) ||
                        (r.start_pos > position_i &&
                         r.start_pos - position_i >= MIN_SPAN)) begin
                        n.teach = TS_OK;
                    end else begin
                        n.teach = TS_FAIL;
                    end
                end
            end
            TS_OK: begin
                if (r.tick && r.tcnt == K_DONE - 15'h0001) begin
                    n.teach = TS_READY;
                    n.valid = 1'b1;
                end
            end
            TS_FAIL: begin
                if (r.tick && r.tcnt == K_DONE - 15'h0001) begin
                    n.teach = TS_NOVAL;
                end
            end
            default: begin
                // Unused code: fall back to the safe no-values state
                n.teach = TS_NOVAL;
                n.valid = 1'b0;
            end
        endcase
        if (n.teach != r.teach) begin
            n.tcnt = '0;
        end

        // Indication state, faults first
        if (fault) begin
            ind_sel = IND_FAULT;
        end else if (r.meas_err) begin
            ind_sel = IND_MEAS;
        end else if (r.svc) begin
            ind_sel = IND_SVC;
        end else begin
            unique case (r.teach)
                TS_CAPS: ind_sel = IND_CAPS;
                TS_WAIT: ind_sel = IND_WAIT;
                TS_CAPN: ind_sel = IND_CAPN;
                TS_OK: ind_sel = IND_OK;
                TS_FAIL: ind_sel = IND_FAIL;
                TS_NOVAL: ind_sel = IND_NOVAL;
                TS_READY: begin
                    if (r.filt.supply_ok) begin
                        ind_sel = IND_READY;
                    end else if (r.filt.supply_low) begin
                        ind_sel = IND_LOWSUP;
                    end else begin
                        ind_sel = IND_OFF;
                    end
                end
                default: ind_sel = IND_NOVAL;
            endcase
        end
        n.ind = ind_sel;
        if (ind_sel != r.ind) begin
            n.phase = '0;
        end else if (r.tick) begin
            if (r.phase == ind_period(r.ind) - 15'h0001) begin
                n.phase = '0;
            end else begin
                n.phase = r.phase + 15'h0001;
            end
        end

        // Patterns; orange is red and green together
        n.led_r = 1'b0;
        n.led_g = 1'b0;
        n.buzz = 1'b0;
        unique case (r.ind)
            IND_OFF: n.buzz = 1'b0;
            IND_READY: n.led_g = blink(r.phase, K_BLIP, K_SLOW);
            IND_LOWSUP: begin
                n.led_r = blink(r.phase, K_BLIP, K_SLOW);
                n.led_g = n.led_r;
            end
            IND_CAPS: begin
                n.led_r = blink(r.phase, K_HALF, K_SEC);
                n.led_g = n.led_r;
                n.buzz = n.led_r;
            end
            IND_WAIT: begin
                n.led_r = 1'b1;
                n.led_g = 1'b1;
                n.buzz = 1'b1;
            end
            IND_CAPN: begin
                n.led_r = blink(r.phase, K_QUART, K_HALF);
                n.led_g = n.led_r;
                n.buzz = n.led_r;
            end
            IND_OK: begin
                n.led_g = 1'b1;
                n.buzz = 1'b1;
            end
            IND_FAIL: begin
                n.led_r = blink(r.phase, K_BLIP, K_FAST);
                n.buzz = 1'b1;
            end
            IND_NOVAL: begin
                n.led_r = 1'b1;
                n.led_g = 1'b1;
                n.buzz = r.phase < K_NV_BURST && blink(r.phase, K_HALF, K_SEC);
            end
            IND_MEAS: begin
                n.led_r = 1'b1;
                n.buzz = r.phase < K_ME_BURST && blink(r.phase, K_HALF, K_SEC);
            end
            IND_SVC: begin
                n.led_r = blink(r.phase, K_HALF, K_SEC);
                n.led_g = ~n.led_r;
                n.buzz = blink(r.phase, K_BLIP, K_SLOW);
            end
            IND_FAULT: begin
                n.led_r = 1'b1;
                n.led_g = blink(r.phase, K_HALF, K_SEC);
            end
        endcase
        if (r.buzz_off) begin
            n.buzz = 1'b0;
        end

        // Command output scaled over the learned travel
        span = r.dir_open ? r.nom_pos - r.start_pos : r.start_pos - r.nom_pos;
        if (r.dir_open) begin
            travel = position_i > r.start_pos ? position_i - r.start_pos : '0;
        end else begin
            travel = r.start_pos > position_i ? r.start_pos - position_i : '0;
        end
        if (travel > span) begin
            travel = span;
        end
        // Divider is costly but runs once per output update, no rate limit needed
        prod = {14'h0000, travel} * {12'h000, (r.range0 ? MV_SPAN_0 : MV_SPAN_2)};
        quot = span == '0 ? '0 : prod / {14'h0000, span};
        scaled = (r.range0 ? 14'h0000 : MV_LOW) + quot[13:0];
        if (r.filt.spring_low) begin
            n.cmd_mv = MV_MAX_AIR;
        end else if (r.svc && r.meas_err) begin
            n.cmd_mv = MV_OPEN;
        // Without learned travel hold the closed-sash level, the safe minimum airflow
        end else if (!r.valid) begin
            n.cmd_mv = r.range0 ? 14'h0000 : MV_LOW;
        end else begin
            n.cmd_mv = scaled;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    assign rdata_o = r.rdata;
    assign led_red_o = r.led_r;
    assign led_green_o = r.led_g;
    assign buzzer_o = r.buzz;
    // Open collector: the pin only ever pulls low
    assign alarm_o = 1'b0;
    assign alarm_oe_o = r.alarm_oe;
    assign cmd_mv_o = r.cmd_mv;
    assign baud_en_o = r.baud_en;

endmodule
`default_nettype wire

// ===== dv/ssi_top_asserts.sv
`default_nettype none
module ssi_top_asserts
    import ssi_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire ssi_pins_type pins_i,
    input wire logic [11:0] position_i,
    input wire ssi_bus_type bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic led_red_o,
    input wire logic led_green_o,
    input wire logic buzzer_o,
    input wire logic alarm_o,
    input wire logic alarm_oe_o,
    input wire logic [13:0] cmd_mv_o,
    input wire logic baud_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mute_r;
    logic seen_r;
    logic [10:0] gap_r;
    wire logic flt = pins_i.spring_low | pins_i.short_travel | pins_i.excess_travel;
    wire logic bad = (position_i < POS_MIN) || (position_i > POS_MAX);
    // Mirror of the mute bit, so the buzzer can be judged without reading back
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mute_r <= 1'b0;
            seen_r <= 1'b0;
            gap_r <= '0;
        end else begin
            if (bus_i.wr && bus_i.addr == REG_CTRL) begin
                mute_r <= bus_i.wdata[CTRL_BUZZ_OFF];
            end
            seen_r <= seen_r | baud_en_o;
            gap_r <= baud_en_o ? 11'h000 : gap_r + 11'h001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rdata_idle;
        !$past(bus_i.rd) |-> rdata_o == 32'h0;
    endproperty
    property p_alarm_on;
        flt [*8] |-> alarm_oe_o && !alarm_o;
    endproperty
    property p_alarm_off;
        !flt [*8] |-> !alarm_oe_o;
    endproperty
    property p_max_air;
        pins_i.spring_low [*8] |-> cmd_mv_o == MV_MAX_AIR;
    endproperty
    property p_baud;
        seen_r |-> (baud_en_o ? gap_r == 11'(BAUD_CYC - 1) : gap_r < 11'(BAUD_CYC - 1));
    endproperty
    property p_mute;
        mute_r [*4] |-> !buzzer_o;
    endproperty
    property p_fault_led;
        flt [*8] |-> led_red_o && !buzzer_o;
    endproperty
    property p_meas_red;
        (bad && !flt) [*8] |-> led_red_o && !led_green_o;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    a_alarm_on: assert property (p_alarm_on) else $error("alarm not pulled");
    a_alarm_off: assert property (p_alarm_off) else $error("alarm stuck");
    a_max_air: assert property (p_max_air) else $error("command not max air");
    a_baud: assert property (p_baud) else $error("bit rate period wrong");
    a_mute: assert property (p_mute) else $error("buzzer sounds while muted");
    a_fault_led: assert property (p_fault_led) else $error("fault pattern wrong");
    a_meas_red: assert property (p_meas_red) else $error("meas error led wrong");
    c_alarm: cover property ($rose(alarm_oe_o));
    c_buzz: cover property (buzzer_o && !mute_r);
    c_baud: cover property (baud_en_o && seen_r);
endmodule
bind ssi_top ssi_top_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins_i), .position_i(position_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .led_red_o(led_red_o), .led_green_o(led_green_o),
    .buzzer_o(buzzer_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o),
    .cmd_mv_o(cmd_mv_o), .baud_en_o(baud_en_o)
);
`default_nettype wire

// ===== dv/ssi_avc_model.sv
`default_nettype none
module ssi_avc_model
    import ssi_pkg::*;
(
    input wire logic clk_i,
    input wire logic alarm_o,
    input wire logic alarm_oe_o,
    input wire logic [13:0] cmd_mv_o,
    output logic alarm_line_o,
    output logic max_air_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up on the open-collector line: high whenever nobody sinks it
    assign alarm_line_o = alarm_oe_o ? alarm_o : 1'b1;
    // Single slave on this segment, polled by one master
    always_ff @(posedge clk_i) begin
        max_air_o <= cmd_mv_o >= MV_MAX_AIR;
    end
endmodule
`default_nettype wire

// ===== dv/tb_sash_status_indicator.sv
`default_nettype none
module tb_sash_status_indicator
    import ssi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TCK = 10;
    localparam logic [31:0] TI = 32'h0000_0FE0;
    logic clk_i = 1'b0;
    logic nrst_i;
    ssi_pins_type pins;
    logic [11:0] position;
    ssi_bus_type bus;
    logic [31:0] rdata_o;
    logic led_red_o, led_green_o, buzzer_o, alarm_o, alarm_oe_o, rd_d, max_air;
    logic [13:0] cmd_mv_o;
    wire logic alarm_line;
    logic [31:0] mq[$];
    logic [31:0] eq[$];
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #2.5 clk_i = ~clk_i;
    ssi_top #(.TICK_CYC(TCK)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .pins_i({pins[6:1], ~alarm_line}),
        .position_i(position), .bus_i(bus), .rdata_o(rdata_o), .led_red_o(led_red_o),
        .led_green_o(led_green_o), .buzzer_o(buzzer_o), .alarm_o(alarm_o),
        .alarm_oe_o(alarm_oe_o), .cmd_mv_o(cmd_mv_o), .baud_en_o()
    );
    ssi_avc_model u_avc (
        .clk_i(clk_i), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o), .cmd_mv_o(cmd_mv_o),
        .alarm_line_o(alarm_line), .max_air_o(max_air)
    );
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    // Expectation is queued when the read is launched; the monitor pops it
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        mq.push_back(m);
        eq.push_back(e);
        @(posedge clk_i);
        bus.rd <= 1'b0;
    endtask
    function automatic logic [31:0] st(input ssi_teach_type t, input ssi_ind_type i);
        return {20'h0, i, t, 5'h0};
    endfunction
    task automatic teach(input logic [11:0] s, input logic [11:0] n, input ssi_teach_type r,
                         input ssi_ind_type ri, input logic [2:0] leds);
        @(posedge clk_i);
        position <= s;
        wr(REG_CTRL, 32'h4);
        wt(10);
        rd(REG_STAT, TI, st(TS_CAPS, IND_CAPS));
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h7);
        wt(1010 * TCK);
        rd(REG_STAT, TI, st(TS_WAIT, IND_WAIT));
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h7);
        @(posedge clk_i);
        position <= n;
        pins.teach_btn <= 1'b1;
        wt(6);
        pins.teach_btn <= 1'b0;
        wt(10);
        rd(REG_STAT, TI, st(TS_CAPN, IND_CAPN));
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h7);
        // Lands in a lit half of the fast red blink
        wt(1005 * TCK);
        rd(REG_STAT, TI, st(r, ri));
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'(leds));
        wt(310 * TCK);
    endtask
    always @(posedge clk_i) begin
        rd_d <= bus.rd;
        if (rd_d) begin
            chk(rdata_o & mq.pop_front(), eq.pop_front());
        end
    end
    // Longest path is two teach runs plus the service timeout, some 8000 cycles below this
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 95000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        logic [11:0] p0;
        logic [7:0] ua;
        nrst_i = 1'b0;
        bus = '0;
        pins = '0;
        pins.supply_ok = 1'b1;
        position = 12'h100;
        void'($urandom(32'h4872E830));
        wt(20);
        nrst_i <= 1'b1;
        wt(10);
        rd(REG_STAT, TI | 32'h6, st(TS_NOVAL, IND_NOVAL));
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h7);
        rd(REG_CMD, 32'h3FFF, 32'(MV_LOW));
        ua = 8'h20 + 8'($urandom % 64);
        wr(ua, $urandom);
        rd(ua, 32'hFFFF_FFFF, 32'h0);
        rd(REG_CTRL, 32'hF, 32'h0);
        wr(REG_CTRL, 32'h2);
        wt(3);
        rd(REG_CTRL, 32'hF, 32'h2);
        rd(REG_CMD, 32'h3FFF, 32'h0);
        wr(REG_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            pins[4 - i] <= 1'b1;
            wt(10);
            rd(REG_STAT, 32'hF04, 32'hB04);
            chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h6);
            rd(REG_CMD, 32'h3FFF, i == 0 ? 32'(MV_MAX_AIR) : 32'(MV_LOW));
            chk(32'(max_air), 32'(i == 0));
            pins[4 - i] <= 1'b0;
            wt(10);
        end
        @(posedge clk_i);
        position <= 12'($urandom % 16);
        wt(10);
        rd(REG_STAT, 32'hF08, 32'h908);
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h5);
        wr(REG_CTRL, 32'h9);
        wt(5);
        chk(32'({led_red_o, buzzer_o}), 32'h2);
        rd(REG_CMD, 32'h3FFF, 32'(MV_OPEN));
        rd(REG_STAT, 32'hF18, 32'h918);
        @(posedge clk_i);
        position <= 12'h100;
        wt(10);
        rd(REG_STAT, 32'hF10, 32'hA10);
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h4);
        wt(1990 * TCK);
        rd(REG_STAT, 32'h10, 32'h10);
        wt(2010 * TCK);
        rd(REG_STAT, 32'hF10, 32'h800);
        wr(REG_CTRL, 32'h0);
        p0 = 12'h100 + 12'($urandom % 256);
        teach(p0, p0 + 12'h020, TS_FAIL, IND_FAIL, 3'b101);
        teach(p0, p0 + 12'h200, TS_OK, IND_OK, 3'b011);
        rd(REG_STAT, TI | 32'h3, st(TS_READY, IND_READY) | 32'h3);
        @(posedge clk_i);
        position <= p0 + 12'h100;
        wt(4);
        rd(REG_CMD, 32'h3FFF, 32'h1770);
        @(posedge clk_i);
        pins.supply_ok <= 1'b0;
        pins.supply_low <= 1'b1;
        wt(10);
        rd(REG_STAT, 32'hF00, 32'h200);
        chk(32'({led_red_o, led_green_o, buzzer_o}), 32'h6);
        wt(4);
        give_verdict();
    end
endmodule
`default_nettype wire
